// ### verilog/wake_ctl_pkg.sv
// Package of register offsets, fields, reset values and timing constants for the wakeup control
package wake_ctl_pkg;
    // ------------------------------------------------------------
    // Register offsets in the special function register space
    // ------------------------------------------------------------
    localparam logic [7:0] RTC_WAKE_INTERVAL_SELECT_ADDR = 8'h96;
    localparam logic [7:0] WAKE_PIN_EDGE_CONTROL_ADDR = 8'hc7;
    localparam logic [7:0] WAKE_SOURCE_CONTROL_ADDR = 8'hc9;
    localparam logic [7:0] RTC_SECONDS_WAKE_INTERVAL_ADDR = 8'hdf;
    localparam logic [7:0] REG_RESET = 8'h00;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int PIN4_EDGE_LSB = 6;
    localparam int PIN3_EDGE_LSB = 4;
    localparam int PIN1_EDGE_LSB = 2;
    localparam int PIN2_EDGE_LSB = 0;
    localparam int PULSE_WAKE_ENABLE_BIT = 2;
    localparam int PORT_ZERO_WAKE_ENABLE_BIT = 1;
    localparam int RESUME_WITHOUT_RESET_BIT = 0;
    localparam int SEC_UNLOCK_BIT = 6;
    localparam int SEC_FIELD_MSB = 5;
    localparam int INTERVAL_MSB = 2;
    localparam logic [7:0] INTERVAL_UNLOCK_VALUE = 8'h07;
    localparam logic [7:0] SOURCE_CTL_MASK = 8'h07;
    localparam logic [5:0] SEC_ZERO = 6'h00;

    // Edge selection codes
    typedef enum logic [1:0]
    {
        EDGE_FALL = 2'b00,
        EDGE_RISE = 2'b01,
        EDGE_BOTH = 2'b10,
        EDGE_FALL_ALT = 2'b11
    } edge_sel_t;

    // Interval selection codes
    localparam logic [2:0] IVL_1S = 3'h0;
    localparam logic [2:0] IVL_1MIN = 3'h1;
    localparam logic [2:0] IVL_1H = 3'h2;
    localparam logic [2:0] IVL_1D = 3'h3;
    localparam logic [2:0] IVL_500MS = 3'h4;
    localparam logic [2:0] IVL_250MS = 3'h5;
    localparam logic [2:0] IVL_125MS = 3'h6;
    localparam logic [2:0] IVL_62MS = 3'h7;

    // ------------------------------------------------------------
    // Timing: interval counted in 62.5 ms ticks (16 per second)
    // ------------------------------------------------------------
    localparam int TICKS_PER_SEC = 16;
    localparam int SECS_PER_MIN = 60;
    localparam int SECS_PER_HOUR = 3600;
    localparam int SECS_PER_DAY = 86400;
    localparam int TICK_CNT_W = 21;
endpackage

// ### verilog/wake_pin_edge.sv
// Synchroniser and selectable edge detector for one wakeup pin
`timescale 1ns/10ps
module wake_pin_edge
(
    input wire logic CLK_I,
    input wire logic RESET_I,
    input wire logic pin_i,
    input wire logic [1:0] edge_sel_i,
    output logic hit_o
);
    logic sync_a;
    logic sync_b;
    logic prev;
    logic rise;
    logic fall;

    always_ff @(posedge CLK_I or posedge RESET_I)
    begin
        if (RESET_I)
        begin
            sync_a <= 1'b1;
            sync_b <= 1'b1;
            prev <= 1'b1;
        end
        else
        begin
            sync_a <= pin_i;
            sync_b <= sync_a;
            prev <= sync_b;
        end
    end

    assign rise = sync_b & ~prev;
    assign fall = ~sync_b & prev;

    // One pulse per qualified edge, seen after two stages
    always_comb
    begin
        unique case (wake_ctl_pkg::edge_sel_t'(edge_sel_i))
            wake_ctl_pkg::EDGE_RISE: hit_o = rise;
            wake_ctl_pkg::EDGE_BOTH: hit_o = rise | fall;
            wake_ctl_pkg::EDGE_FALL, wake_ctl_pkg::EDGE_FALL_ALT: hit_o = fall;
        endcase
    end
endmodule

// ### verilog/sleep_wakeup_control.sv
// Wakeup control: edge select, wake sources, RTC interval and seconds unlock
`timescale 1ns/10ps

// Functional notes
// - Each two-bit edge field picks falling on 00/11, rising on 01, either on 10; pin four uses bits 7:6.
// - Pin three's edge field is bits 5:4 with the same coding.
// - Pin one's edge field is bits 3:2 with the same coding.
// - Pin two's edge field is bits 1:0 with the same coding, and all edge fields reset to zero.
// - Source control bit 2 lets an energy pulse wake the light sleep state.
// - Source control bit 1 enables wakeups from pins three and four.
// - With bit 0 set a pin wakeup resumes and clears sleep request and fast wake bits.
// - With bit 0 clear a pin wakeup resets the system into the oscillator-clocked state.
// - The three-bit interval field picks 1 s, 1 min, 1 h, 1 day, 500, 250, 125 or 62.5 ms.
// - Seconds bits 5:0 are writable only after 0x07 to the interval register then bit 6 set.
// - A seconds value of 1 to 63 wakes light sleep every value plus one seconds.
// - A seconds value of zero forces a 62.5 ms interval.
// - Any pin wakeup sets the pin wake status flag.
// - An energy-pulse wakeup sets the pulse wake flag with the shared timer/pulse flag.
module sleep_wakeup_control
(
    input wire logic CLK_I,
    input wire logic RESET_I,
    input wire logic [7:0] SFR_ADDR_I,
    input wire logic [7:0] SFR_WDATA_I,
    input wire logic SFR_WR_I,
    input wire logic SFR_RD_I,
    output logic [7:0] SFR_RDATA_O,
    input wire logic WAKE_PIN_ONE_I,
    input wire logic WAKE_PIN_TWO_I,
    input wire logic WAKE_PIN_THREE_I,
    input wire logic WAKE_PIN_FOUR_I,
    input wire logic TICK_62MS_I,
    input wire logic ENERGY_PULSE_I,
    input wire logic LIGHT_SLEEP_I,
    input wire logic DEEP_SLEEP_I,
    input wire logic FLAG_CLEAR_I,
    output logic WAKE_O,
    output logic RESUME_O,
    output logic SYS_RESET_O,
    output logic CLEAR_SLEEP_BITS_O,
    output logic PIN_WAKE_FLAG_O,
    output logic TIMER_PULSE_FLAG_O,
    output logic PULSE_WAKE_FLAG_O,
    output logic [3:0] PIN_WAKE_FLAGS_O
);
    logic [7:0] rtc_wake_interval_select;
    logic [7:0] wake_pin_edge_control;
    logic [7:0] wake_source_control;
    logic [7:0] rtc_seconds_wake_interval;
    logic interval_unlock_seen;
    logic [3:0] pin_hit;
    logic [3:0] pin_ok;
    logic [3:0] pin_level;
    logic asleep;
    logic io_wake;
    logic pulse_wake;
    logic rtc_wake;
    logic [wake_ctl_pkg::TICK_CNT_W-1:0] tick_cnt;
    logic [wake_ctl_pkg::TICK_CNT_W-1:0] tick_limit;
    logic wr_edge;
    logic wr_src;
    logic wr_ivl;
    logic wr_sec;

    // Strobe is an argument so the decodes follow it even when the address stays put
    function automatic logic hit(input logic strobe, input logic [7:0] a, input logic [7:0] b);
        hit = strobe && (a == b);
    endfunction

    assign wr_edge = hit(SFR_WR_I, SFR_ADDR_I, wake_ctl_pkg::WAKE_PIN_EDGE_CONTROL_ADDR);
    assign wr_src = hit(SFR_WR_I, SFR_ADDR_I, wake_ctl_pkg::WAKE_SOURCE_CONTROL_ADDR);
    assign wr_ivl = hit(SFR_WR_I, SFR_ADDR_I, wake_ctl_pkg::RTC_WAKE_INTERVAL_SELECT_ADDR);
    assign wr_sec = hit(SFR_WR_I, SFR_ADDR_I, wake_ctl_pkg::RTC_SECONDS_WAKE_INTERVAL_ADDR);
    assign asleep = LIGHT_SLEEP_I | DEEP_SLEEP_I;
    assign pin_level = {WAKE_PIN_FOUR_I, WAKE_PIN_THREE_I, WAKE_PIN_TWO_I, WAKE_PIN_ONE_I};

    // ------------------------------------------------------------
    // Pin edge detection
    // ------------------------------------------------------------
    // Edge field LSB per pin index: pin one, two, three, four
    function automatic int edge_lsb(input int idx);
        unique case (idx)
            0: edge_lsb = wake_ctl_pkg::PIN1_EDGE_LSB;
            1: edge_lsb = wake_ctl_pkg::PIN2_EDGE_LSB;
            2: edge_lsb = wake_ctl_pkg::PIN3_EDGE_LSB;
            default: edge_lsb = wake_ctl_pkg::PIN4_EDGE_LSB;
        endcase
    endfunction

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_pin
            wake_pin_edge u_edge
            (
                .CLK_I(CLK_I),
                .RESET_I(RESET_I),
                .pin_i(pin_level[gi]),
                .edge_sel_i(wake_pin_edge_control[edge_lsb(gi)+:2]),
                .hit_o(pin_hit[gi])
            );
        end
    endgenerate

    // Pins three and four are gated by the port zero enable
    assign pin_ok[1:0] = pin_hit[1:0];
    assign pin_ok[3:2] = pin_hit[3:2]
        & {2{wake_source_control[wake_ctl_pkg::PORT_ZERO_WAKE_ENABLE_BIT]}};
    assign io_wake = asleep && (|pin_ok);
    // Pulse wake only from light sleep
    assign pulse_wake = LIGHT_SLEEP_I && ENERGY_PULSE_I
        && wake_source_control[wake_ctl_pkg::PULSE_WAKE_ENABLE_BIT];

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge CLK_I or posedge RESET_I)
    begin
        if (RESET_I)
            wake_pin_edge_control <= wake_ctl_pkg::REG_RESET;
        else if (wr_edge)
            wake_pin_edge_control <= SFR_WDATA_I;
    end

    always_ff @(posedge CLK_I or posedge RESET_I)
    begin
        if (RESET_I)
            wake_source_control <= wake_ctl_pkg::REG_RESET;
        else if (wr_src)
            wake_source_control <= SFR_WDATA_I & wake_ctl_pkg::SOURCE_CTL_MASK;
    end

    always_ff @(posedge CLK_I or posedge RESET_I)
    begin
        if (RESET_I)
            rtc_wake_interval_select <= wake_ctl_pkg::REG_RESET;
        else if (wr_ivl)
            rtc_wake_interval_select <= SFR_WDATA_I;
    end

    // Unlock step one: interval register holds 0x07 when bit 6 gets set
    assign interval_unlock_seen =
        (rtc_wake_interval_select == wake_ctl_pkg::INTERVAL_UNLOCK_VALUE);

    always_ff @(posedge CLK_I or posedge RESET_I)
    begin
        if (RESET_I)
            rtc_seconds_wake_interval <= wake_ctl_pkg::REG_RESET;
        else if (wr_sec)
        begin
            // Bit 7 always writable; unlock bit only armed after 0x07
            rtc_seconds_wake_interval[7] <= SFR_WDATA_I[7];
            rtc_seconds_wake_interval[wake_ctl_pkg::SEC_UNLOCK_BIT] <=
                SFR_WDATA_I[wake_ctl_pkg::SEC_UNLOCK_BIT] & interval_unlock_seen;
            if (rtc_seconds_wake_interval[wake_ctl_pkg::SEC_UNLOCK_BIT] && interval_unlock_seen)
                rtc_seconds_wake_interval[wake_ctl_pkg::SEC_FIELD_MSB:0] <=
                    SFR_WDATA_I[wake_ctl_pkg::SEC_FIELD_MSB:0];
        end
    end

    always_ff @(posedge CLK_I or posedge RESET_I)
    begin
        if (RESET_I)
            SFR_RDATA_O <= wake_ctl_pkg::REG_RESET;
        else if (SFR_RD_I)
        begin
            unique case (SFR_ADDR_I)
                wake_ctl_pkg::RTC_WAKE_INTERVAL_SELECT_ADDR: SFR_RDATA_O <= rtc_wake_interval_select;
                wake_ctl_pkg::WAKE_PIN_EDGE_CONTROL_ADDR: SFR_RDATA_O <= wake_pin_edge_control;
                wake_ctl_pkg::WAKE_SOURCE_CONTROL_ADDR: SFR_RDATA_O <= wake_source_control;
                wake_ctl_pkg::RTC_SECONDS_WAKE_INTERVAL_ADDR: SFR_RDATA_O <= rtc_seconds_wake_interval;
                default: SFR_RDATA_O <= wake_ctl_pkg::REG_RESET;
            endcase
        end
    end

    // ------------------------------------------------------------
    // RTC interval in 62.5 ms ticks
    // ------------------------------------------------------------
    always_comb
    begin
        tick_limit = wake_ctl_pkg::TICK_CNT_W'(wake_ctl_pkg::TICKS_PER_SEC);
        if (interval_unlock_seen)
        begin
            if (rtc_seconds_wake_interval[wake_ctl_pkg::SEC_FIELD_MSB:0] == wake_ctl_pkg::SEC_ZERO)
                tick_limit = wake_ctl_pkg::TICK_CNT_W'(
                    wake_ctl_pkg::TICKS_PER_SEC / wake_ctl_pkg::TICKS_PER_SEC);
            else
                tick_limit = wake_ctl_pkg::TICK_CNT_W'(wake_ctl_pkg::TICKS_PER_SEC
                    * (int'(rtc_seconds_wake_interval[wake_ctl_pkg::SEC_FIELD_MSB:0]) + 1));
        end
        else
        begin
            unique case (rtc_wake_interval_select[wake_ctl_pkg::INTERVAL_MSB:0])
                wake_ctl_pkg::IVL_1S: tick_limit = wake_ctl_pkg::TICK_CNT_W'(wake_ctl_pkg::TICKS_PER_SEC);
                wake_ctl_pkg::IVL_1MIN: tick_limit = wake_ctl_pkg::TICK_CNT_W'(
                    wake_ctl_pkg::TICKS_PER_SEC * wake_ctl_pkg::SECS_PER_MIN);
                wake_ctl_pkg::IVL_1H: tick_limit = wake_ctl_pkg::TICK_CNT_W'(
                    wake_ctl_pkg::TICKS_PER_SEC * wake_ctl_pkg::SECS_PER_HOUR);
                wake_ctl_pkg::IVL_1D: tick_limit = wake_ctl_pkg::TICK_CNT_W'(
                    wake_ctl_pkg::TICKS_PER_SEC * wake_ctl_pkg::SECS_PER_DAY);
                wake_ctl_pkg::IVL_500MS: tick_limit = wake_ctl_pkg::TICK_CNT_W'(
                    wake_ctl_pkg::TICKS_PER_SEC / 2);
                wake_ctl_pkg::IVL_250MS: tick_limit = wake_ctl_pkg::TICK_CNT_W'(
                    wake_ctl_pkg::TICKS_PER_SEC / 4);
                wake_ctl_pkg::IVL_125MS: tick_limit = wake_ctl_pkg::TICK_CNT_W'(
                    wake_ctl_pkg::TICKS_PER_SEC / 8);
                wake_ctl_pkg::IVL_62MS: tick_limit = wake_ctl_pkg::TICK_CNT_W'(
                    wake_ctl_pkg::TICKS_PER_SEC / wake_ctl_pkg::TICKS_PER_SEC);
            endcase
        end
    end

    // Counts only in light sleep so every sleep starts a full interval
    always_ff @(posedge CLK_I or posedge RESET_I)
    begin
        if (RESET_I)
            tick_cnt <= '0;
        else if (!LIGHT_SLEEP_I)
            tick_cnt <= '0;
        else if (TICK_62MS_I)
            tick_cnt <= (tick_cnt + 1'b1 >= tick_limit) ? '0 : tick_cnt + 1'b1;
    end

    assign rtc_wake = LIGHT_SLEEP_I && TICK_62MS_I && (tick_cnt + 1'b1 >= tick_limit);

    // ------------------------------------------------------------
    // Wake outputs and status flags
    // ------------------------------------------------------------
    always_ff @(posedge CLK_I or posedge RESET_I)
    begin
        if (RESET_I)
        begin
            WAKE_O <= 1'b0;
            RESUME_O <= 1'b0;
            SYS_RESET_O <= 1'b0;
            CLEAR_SLEEP_BITS_O <= 1'b0;
        end
        else
        begin
            WAKE_O <= io_wake | pulse_wake | rtc_wake;
            RESUME_O <= io_wake & wake_source_control[wake_ctl_pkg::RESUME_WITHOUT_RESET_BIT];
            CLEAR_SLEEP_BITS_O <= io_wake
                & wake_source_control[wake_ctl_pkg::RESUME_WITHOUT_RESET_BIT];
            SYS_RESET_O <= io_wake & ~wake_source_control[wake_ctl_pkg::RESUME_WITHOUT_RESET_BIT];
        end
    end

    // Flags: a new event wins over a clear in the same cycle
    always_ff @(posedge CLK_I or posedge RESET_I)
    begin
        if (RESET_I)
        begin
            PIN_WAKE_FLAG_O <= 1'b0;
            TIMER_PULSE_FLAG_O <= 1'b0;
            PULSE_WAKE_FLAG_O <= 1'b0;
            PIN_WAKE_FLAGS_O <= '0;
        end
        else
        begin
            PIN_WAKE_FLAG_O <= io_wake | (PIN_WAKE_FLAG_O & ~FLAG_CLEAR_I);
            TIMER_PULSE_FLAG_O <= pulse_wake | rtc_wake | (TIMER_PULSE_FLAG_O & ~FLAG_CLEAR_I);
            PULSE_WAKE_FLAG_O <= pulse_wake
                | (PULSE_WAKE_FLAG_O & ~FLAG_CLEAR_I & ~rtc_wake);
            PIN_WAKE_FLAGS_O <= (pin_ok & {4{io_wake}}) | (PIN_WAKE_FLAGS_O & {4{~FLAG_CLEAR_I}});
        end
    end
endmodule

// ### tb/wake_source_model.sv
// Far-side model: wake pins, RTC tick source and energy pulse
`timescale 1ns/10ps
module wake_source_model
(
    input wire logic clk_i,
    input wire logic tick_en_i,
    output logic [3:0] pin_o,
    output logic tick_o,
    output logic pulse_o
);
    initial
    begin
        pin_o = 4'hf;
        tick_o = 1'b0;
        pulse_o = 1'b0;
    end
    // A tick every cycle stands in for the 62.5 ms tick to keep runs short
    always @(posedge clk_i)
        tick_o <= tick_en_i;
    task automatic set_pin(input int p, input logic v);
        @(posedge clk_i);
        pin_o[p] <= v;
    endtask
    task automatic fire_pulse();
        @(posedge clk_i);
        pulse_o <= 1'b1;
        @(posedge clk_i);
        pulse_o <= 1'b0;
    endtask
endmodule

// ### tb/wake_ctl_properties.sv
// Concurrent checks on the wakeup control ports
`timescale 1ns/10ps
module wake_ctl_checker
(
    input wire logic CLK_I,
    input wire logic RESET_I,
    input wire logic [7:0] SFR_ADDR_I,
    input wire logic SFR_RD_I,
    input wire logic [7:0] SFR_RDATA_O,
    input wire logic LIGHT_SLEEP_I,
    input wire logic DEEP_SLEEP_I,
    input wire logic WAKE_O,
    input wire logic RESUME_O,
    input wire logic SYS_RESET_O,
    input wire logic CLEAR_SLEEP_BITS_O,
    input wire logic PIN_WAKE_FLAG_O,
    input wire logic TIMER_PULSE_FLAG_O,
    input wire logic PULSE_WAKE_FLAG_O
);
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (RESET_I);
    // ----------------------------------------
    // Wake outcome relations and the source control read check
    // ----------------------------------------
    resume_only_a: assert property (RESUME_O |-> WAKE_O && !SYS_RESET_O)
        else $error("resume pulse without wake or with reset");
    clear_pair_a: assert property (RESUME_O == CLEAR_SLEEP_BITS_O)
        else $error("clear of sleep bits differs from resume");
    reset_only_a: assert property (SYS_RESET_O |-> WAKE_O && !RESUME_O)
        else $error("reset pulse without wake or with resume");
    pin_flag_a: assert property ((RESUME_O || SYS_RESET_O) |-> PIN_WAKE_FLAG_O)
        else $error("pin wake without pin flag");
    pin_flag_rise_a: assert property ($rose(PIN_WAKE_FLAG_O) |-> WAKE_O)
        else $error("pin flag set without wake");
    pulse_flag_a: assert property ($rose(PULSE_WAKE_FLAG_O) |-> TIMER_PULSE_FLAG_O && WAKE_O)
        else $error("pulse flag set without shared flag");
    pulse_sleep_a: assert property ($rose(PULSE_WAKE_FLAG_O) |-> $past(LIGHT_SLEEP_I))
        else $error("pulse wake outside light sleep");
    timer_flag_a: assert property ($rose(TIMER_PULSE_FLAG_O) |-> WAKE_O && $past(LIGHT_SLEEP_I))
        else $error("timer flag set without light sleep wake");
    awake_quiet_a: assert property ((!LIGHT_SLEEP_I && !DEEP_SLEEP_I) [*6] |-> !RESUME_O && !SYS_RESET_O)
        else $error("pin wake while awake");
    src_read_a: assert property (SFR_RD_I && SFR_ADDR_I == wake_ctl_pkg::WAKE_SOURCE_CONTROL_ADDR
        |=> SFR_RDATA_O[7:3] == 5'h00)
        else $error("source control upper bits not zero");
    resume_c: cover property (RESUME_O);
    reset_c: cover property (SYS_RESET_O);
    pulse_c: cover property ($rose(PULSE_WAKE_FLAG_O));
    timer_c: cover property ($rose(TIMER_PULSE_FLAG_O));
endmodule
bind sleep_wakeup_control wake_ctl_checker wake_ctl_checker_inst (.CLK_I(CLK_I),
    .RESET_I(RESET_I), .SFR_ADDR_I(SFR_ADDR_I), .SFR_RD_I(SFR_RD_I), .SFR_RDATA_O(SFR_RDATA_O),
    .LIGHT_SLEEP_I(LIGHT_SLEEP_I), .DEEP_SLEEP_I(DEEP_SLEEP_I), .WAKE_O(WAKE_O),
    .RESUME_O(RESUME_O), .SYS_RESET_O(SYS_RESET_O), .CLEAR_SLEEP_BITS_O(CLEAR_SLEEP_BITS_O),
    .PIN_WAKE_FLAG_O(PIN_WAKE_FLAG_O), .TIMER_PULSE_FLAG_O(TIMER_PULSE_FLAG_O),
    .PULSE_WAKE_FLAG_O(PULSE_WAKE_FLAG_O));

// ### tb/testbench.sv
// Self-checking bench for the wakeup control block
`timescale 1ns/10ps
module testbench;
    localparam logic [7:0] IVL = wake_ctl_pkg::RTC_WAKE_INTERVAL_SELECT_ADDR;
    localparam logic [7:0] EDG = wake_ctl_pkg::WAKE_PIN_EDGE_CONTROL_ADDR;
    localparam logic [7:0] SRC = wake_ctl_pkg::WAKE_SOURCE_CONTROL_ADDR;
    localparam logic [7:0] SEC = wake_ctl_pkg::RTC_SECONDS_WAKE_INTERVAL_ADDR;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0, rd = 1'b0, clr = 1'b0, light = 1'b0, deep = 1'b0, tick_en = 1'b0;
    logic rd_d = 1'b0, rtc_mode = 1'b0;
    logic [7:0] rdata;
    logic wake, resume, sysrst, clrbits, pflag, tpflag, puflag, tick, pulse;
    logic [3:0] flags, pins;
    logic [9:0] exp_q[$];
    logic [9:0] e;
    logic [31:0] rnd;
    int error_cnt = 0;
    int check_count = 0;
    realtime t_prev = 0;
    realtime t_last = 0;
    realtime t_start = 0;
    int lsb[4] = '{2, 0, 4, 6};
    int ivl[7] = '{7, 7, 0, 1, 4, 5, 6};
    int gap[7] = '{96, 1, 16, 960, 8, 4, 2};
    always #5 clk = ~clk;
    sleep_wakeup_control sleep_wakeup_control_inst (.CLK_I(clk), .RESET_I(rst),
        .SFR_ADDR_I(addr), .SFR_WDATA_I(wdata), .SFR_WR_I(wr), .SFR_RD_I(rd),
        .SFR_RDATA_O(rdata), .WAKE_PIN_ONE_I(pins[0]), .WAKE_PIN_TWO_I(pins[1]),
        .WAKE_PIN_THREE_I(pins[2]), .WAKE_PIN_FOUR_I(pins[3]), .TICK_62MS_I(tick),
        .ENERGY_PULSE_I(pulse), .LIGHT_SLEEP_I(light), .DEEP_SLEEP_I(deep), .FLAG_CLEAR_I(clr),
        .WAKE_O(wake), .RESUME_O(resume), .SYS_RESET_O(sysrst), .CLEAR_SLEEP_BITS_O(clrbits),
        .PIN_WAKE_FLAG_O(pflag), .TIMER_PULSE_FLAG_O(tpflag), .PULSE_WAKE_FLAG_O(puflag),
        .PIN_WAKE_FLAGS_O(flags));
    wake_source_model wake_source_model_inst (.clk_i(clk), .tick_en_i(tick_en),
        .pin_o(pins), .tick_o(tick), .pulse_o(pulse));
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        check_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic [9:0] pop();
        if (exp_q.size() == 0)
            return 10'h3ff;
        return exp_q.pop_front();
    endfunction
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        exp_q.push_back({2'b00, d});
        @(posedge clk);
        rd <= 1'b0;
    endtask
    task automatic flag_clear();
        @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
    endtask
    // Any expected result still queued here never appeared at the ports
    task automatic settle();
        repeat (12) @(posedge clk);
        chk(10'(exp_q.size()), 10'h000);
        exp_q.delete();
    endtask
    // ----------------------------------------
    // Result monitor
    // ----------------------------------------
    always @(posedge clk)
        rd_d <= rd;
    always @(negedge clk)
    begin
        if (rd_d)
            chk({2'b00, rdata}, pop());
        if (wake && rtc_mode)
        begin
            t_prev = t_last;
            t_last = $realtime;
        end
        else if (wake)
            chk({resume, sysrst, clrbits, pflag, tpflag, puflag, flags}, pop());
    end
    initial
    begin
        repeat (80000) @(posedge clk);
        error_cnt++;
        end_sim();
    end
    initial
    begin
        void'($urandom(32'h45b51fb7));
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rd_reg(IVL, 8'h00);
        rd_reg(EDG, 8'h00);
        rd_reg(SRC, 8'h00);
        rd_reg(SEC, 8'h00);
        rd_reg(8'h55, 8'h00);
        rnd = $urandom;
        wr_reg(EDG, rnd[7:0]);
        rd_reg(EDG, rnd[7:0]);
        wr_reg(SRC, 8'hff);
        rd_reg(SRC, 8'h07);
        wr_reg(SEC, 8'h45);
        rd_reg(SEC, 8'h00);
        wr_reg(IVL, 8'h07);
        wr_reg(SEC, 8'h40);
        wr_reg(SEC, 8'h45);
        rd_reg(SEC, 8'h45);
        settle();
        $display("register test done");
        for (int p = 0; p < 4; p++)
            for (int c = 0; c < 4; c++)
            begin
                wr_reg(SRC, {7'h01, c[0]});
                wr_reg(EDG, 8'(c << lsb[p]));
                flag_clear();
                // Pins two and four wake from light sleep, pins one and three from deep sleep
                {light, deep} <= p[0] ? 2'b10 : 2'b01;
                e = {c[0], !c[0], c[0], 3'b100, 4'(1 << p)};
                if (c != 1)
                    exp_q.push_back(e);
                wake_source_model_inst.set_pin(p, 1'b0);
                settle();
                flag_clear();
                if (c == 1 || c == 2)
                    exp_q.push_back(e);
                wake_source_model_inst.set_pin(p, 1'b1);
                settle();
                {light, deep} <= 2'b00;
            end
        $display("edge test done");
        wr_reg(SRC, 8'h01);
        wr_reg(EDG, 8'h00);
        deep <= 1'b1;
        wake_source_model_inst.set_pin(2, 1'b0);
        settle();
        deep <= 1'b0;
        wake_source_model_inst.set_pin(2, 1'b1);
        wake_source_model_inst.set_pin(0, 1'b0);
        settle();
        wake_source_model_inst.set_pin(0, 1'b1);
        $display("pin refusal test done");
        wr_reg(SRC, 8'h04);
        flag_clear();
        light <= 1'b1;
        exp_q.push_back(10'h030);
        wake_source_model_inst.fire_pulse();
        settle();
        wr_reg(SRC, 8'h00);
        wake_source_model_inst.fire_pulse();
        settle();
        light <= 1'b0;
        $display("pulse test done");
        rtc_mode <= 1'b1;
        for (int i = 0; i < 7; i++)
        begin
            wr_reg(IVL, 8'h07);
            wr_reg(SEC, (i == 1) ? 8'h40 : 8'h45);
            wr_reg(IVL, 8'(ivl[i]));
            light <= 1'b1;
            tick_en <= 1'b1;
            repeat (gap[i] * 3 + 40) @(posedge clk);
            chk(10'(int'((t_last - t_prev) / 10.0)), 10'(gap[i]));
            light <= 1'b0;
            tick_en <= 1'b0;
            repeat (8) @(posedge clk);
        end
        // Hour code: only the first wake after entry fits in the run
        wr_reg(IVL, 8'h02);
        t_start = $realtime;
        light <= 1'b1;
        tick_en <= 1'b1;
        repeat (wake_ctl_pkg::TICKS_PER_SEC * wake_ctl_pkg::SECS_PER_HOUR + 8) @(posedge clk);
        chk(10'(int'((t_last - t_start) / 10.0)
            - wake_ctl_pkg::TICKS_PER_SEC * wake_ctl_pkg::SECS_PER_HOUR), 10'h002);
        light <= 1'b0;
        tick_en <= 1'b0;
        repeat (8) @(posedge clk);
        rtc_mode <= 1'b0;
        chk({8'h00, tpflag, puflag}, 10'h002);
        $display("interval test done");
        end_sim();
    end
endmodule
